// ===== hdl/fcdma_defs.vh
// Purpose: constants for the four channel transfer controller
// Assumes: byte addressed register bus, one 32-bit word per register
// Notes: offsets and field positions of the control words are local
`ifndef FCDMA_DEFS_VH
`define FCDMA_DEFS_VH
// register map
`define FCDMA_IDX_SRC 2'h0
`define FCDMA_IDX_DST 2'h1
`define FCDMA_IDX_CNT 2'h2
`define FCDMA_IDX_CTL 2'h3
`define FCDMA_ADDR_OPR 8'h40
`define FCDMA_ADDR_SEL01 8'h44
`define FCDMA_ADDR_SEL23 8'h48
// channel control fields
`define FCDMA_CC_EN 0
`define FCDMA_CC_END_FLAG 1
`define FCDMA_CC_INT_EN 2
`define FCDMA_CC_SINGLE 5
`define FCDMA_CC_SDIR 6
`define FCDMA_CC_ACK_POL 9
`define FCDMA_CC_END_POL 10
`define FCDMA_CC_BURST 11
`define FCDMA_CC_INTM 12
`define FCDMA_CC_MASK 20'hF1FFD
// unit size codes, bits 4:3
`define FCDMA_TS_BYTE 2'h0
`define FCDMA_TS_WORD 2'h1
`define FCDMA_TS_LONG 2'h2
`define FCDMA_TS_BLK16 2'h3
// detection codes, bits 8:7
`define FCDMA_DET_LOW 2'h0
`define FCDMA_DET_HIGH 2'h1
`define FCDMA_DET_RISE 2'h2
`define FCDMA_DET_FALL 2'h3
// request source codes, bits 19:16
`define FCDMA_RS_AUTO 4'h0
`define FCDMA_RS_EXT 4'h2
`define FCDMA_RS_PERI 4'h8
// operation control fields
`define FCDMA_OP_MASTER_EN 0
`define FCDMA_OP_NMI_FLAG 1
`define FCDMA_OP_ADDR_ERR 2
`define FCDMA_OP_WMASK 16'h0301
// peripheral module and kind codes
`define FCDMA_MOD_SER0 6'h08
`define FCDMA_MOD_SER1 6'h09
`define FCDMA_MOD_SER2 6'h0A
`define FCDMA_MOD_SIO 6'h14
`define FCDMA_KIND_TX 2'h1
`define FCDMA_KIND_RX 2'h2
// idle cycles between units in intermittent mode
`define FCDMA_INTM_GAP 8'h10
`endif

// ===== hdl/fcdma_top.v
// Purpose: four channel transfer controller with register slave and
//          memory master
// Assumes: ref_clk 25 MHz, all inputs synchronous to ref_clk
// Notes: one memory access at a time; 16-byte units move as 4 longwords
// Notes on behaviour
// - four channels; only channels 0 and 1 take external requests and drive pins
// - unit size byte, word, longword or sixteen bytes as four longwords
// - external request seen as low level, high level, rising or falling edge
// - acknowledge and end outputs each have their own active level
// - source address register readable, writable, shows next source address
// - destination address register readable, writable, shows next destination
// - single address mode, channels 0 and 1 only, ignores the address register on the device side
// - count one means one, zero means two to the twenty-fourth
// - count register holds remaining transfers while running
// - top count byte reads zero; software writes zeros there
// - each sixteen-byte block decrements the count by one
// - end, address error and abort flags clear only by writing zero
// - read in the set cycle returns zero yet a later zero write clears
// - operation register selects priority and reports shared status flags
// - first selector serves channels 0 and 1, second serves 2 and 3
// - peripheral request counts only when source select equals 1000
// - pending requests serviced by priority, channel stops at end
// - burst mode or cycle steal, normal or intermittent
// - channel raises an interrupt when its count completes and its interrupt enable is set
// - transfer only when enables set and all three flags clear
// - count reaching zero ends the channel; interrupt if enabled
// - address error, abort input or cleared enable stops transfers
`timescale 1ns/100ps
`default_nettype none
`include "fcdma_defs.vh"
module fcdma_top #(
  parameter [7:0] INTM_GAP = `FCDMA_INTM_GAP
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [31:0] mem_address,
  output reg mem_read,
  output reg mem_write,
  output reg [31:0] mem_writedata,
  output reg [3:0] mem_byteenable,
  input wire [31:0] mem_readdata,
  input wire mem_waitrequest,
  input wire [1:0] external_request_in,
  input wire [7:0] periph_req,
  input wire nmi_in,
  output reg [1:0] request_acknowledge_out,
  output reg [1:0] transfer_end_out,
  output reg [3:0] channel_end_interrupt
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_CHK = 5'h02;
  localparam [4:0] S_RD = 5'h04;
  localparam [4:0] S_WR = 5'h08;
  localparam [4:0] S_GAP = 5'h10;

  // ==========================================================
  // functions
  function [31:0] mrg;
    input [31:0] o;
    input [31:0] w;
    input [3:0] b;
    integer i;
    begin
      mrg = o;
      for (i = 0; i < 4; i = i + 1) begin
        if (b[i]) mrg[i*8 +: 8] = w[i*8 +: 8];
      end
    end
  endfunction

  function [31:0] step;
    input [1:0] ts;
    begin
      case (ts)
        `FCDMA_TS_BYTE: step = 32'h00000001;
        `FCDMA_TS_WORD: step = 32'h00000002;
        default: step = 32'h00000004;
      endcase
    end
  endfunction

  function [3:0] bef;
    input [1:0] ts;
    input [1:0] a;
    begin
      case (ts)
        `FCDMA_TS_BYTE: bef = 4'h1 << a;
        `FCDMA_TS_WORD: bef = a[1] ? 4'hC : 4'h3;
        default: bef = 4'hF;
      endcase
    end
  endfunction

  // move the addressed lane to every lane of the write word
  function [31:0] repl;
    input [1:0] ts;
    input [31:0] d;
    input [1:0] a;
    reg [31:0] s;
    begin
      s = d >> {a, 3'b000};
      case (ts)
        `FCDMA_TS_BYTE: repl = {4{s[7:0]}};
        `FCDMA_TS_WORD: repl = {2{s[15:0]}};
        default: repl = d;
      endcase
    end
  endfunction

  function [3:0] amask;
    input [1:0] ts;
    begin
      case (ts)
        `FCDMA_TS_BYTE: amask = 4'h0;
        `FCDMA_TS_WORD: amask = 4'h1;
        `FCDMA_TS_LONG: amask = 4'h3;
        default: amask = 4'hF;
      endcase
    end
  endfunction

  // selector byte: module code in 7:2, kind in 1:0
  function psel;
    input [7:0] s;
    input [7:0] pr;
    reg [1:0] m;
    reg ok;
    begin
      ok = 1'b1;
      m = 2'h0;
      case (s[7:2])
        `FCDMA_MOD_SER0: m = 2'h0;
        `FCDMA_MOD_SER1: m = 2'h1;
        `FCDMA_MOD_SER2: m = 2'h2;
        `FCDMA_MOD_SIO: m = 2'h3;
        default: ok = 1'b0;
      endcase
      case (s[1:0])
        `FCDMA_KIND_TX: psel = ok & pr[{m, 1'b0}];
        `FCDMA_KIND_RX: psel = ok & pr[{m, 1'b1}];
        default: psel = 1'b0;
      endcase
    end
  endfunction

  // channel at priority rank i (0 highest)
  function [1:0] ord;
    input [1:0] pr;
    input [1:0] last;
    input [1:0] i;
    begin
      case (pr)
        2'h0: ord = i;
        2'h1: ord = (i == 2'h0) ? 2'h0 : ((i == 2'h3) ? 2'h1 : i + 2'h1);
        default: ord = last + 2'h1 + i;
      endcase
    end
  endfunction

  function [2:0] arb;
    input [3:0] r;
    input [1:0] pr;
    input [1:0] last;
    integer i;
    reg [1:0] ch;
    begin
      arb = 3'h0;
      for (i = 3; i >= 0; i = i - 1) begin
        ch = ord(pr, last, i[1:0]);
        if (r[ch]) arb = {1'b1, ch};
      end
    end
  endfunction

  // ==========================================================
  // state
  reg [31:0] src_addr [0:3];
  reg [31:0] dst_addr [0:3];
  reg [23:0] cnt [0:3];
  reg [19:0] ctl [0:3];
  reg [15:0] opr;
  reg [15:0] sel01;
  reg [15:0] sel23;
  reg [4:0] st;
  reg [1:0] cur;
  reg [1:0] beat;
  reg [1:0] rr_last;
  reg [7:0] gap;
  reg [1:0] pend;
  reg [1:0] prev_req;
  reg [3:0] ready;
  reg [3:0] req;
  reg [1:0] extq;
  reg [31:0] rd_val;
  integer c;
  integer k;

  wire is_ch = (avs_address[7:6] == 2'b00);
  wire [1:0] ach = avs_address[5:4];
  wire [1:0] aix = avs_address[3:2];
  wire wr_go = avs_write & avs_waitrequest;
  wire [31:0] wv = avs_writedata;
  // addressed register with the enabled write lanes merged in
  wire [31:0] wr_val = mrg(rd_val, wv, avs_byteenable);
  wire [19:0] cctl = ctl[cur];
  wire [1:0] ts = cctl[4:3];
  wire sgl = cctl[`FCDMA_CC_SINGLE] & ~cur[1];
  wire sdir = cctl[`FCDMA_CC_SDIR];
  wire ext_mode = (cctl[19:16] == `FCDMA_RS_EXT) & ~cur[1];
  wire is16 = (ts == `FCDMA_TS_BLK16);
  wire unit_last = ~is16 | (beat == 2'h3);
  wire last_unit = (cnt[cur] == 24'h000001);
  wire [31:0] stp = step(ts);
  wire [3:0] am = amask(ts);
  wire bad_src = |(src_addr[cur][3:0] & am) & ~(sgl & ~sdir);
  wire bad_dst = |(dst_addr[cur][3:0] & am) & ~(sgl & sdir);
  wire beat_done = ~mem_waitrequest & (((st == S_RD) & sgl) | (st == S_WR));
  wire [2:0] g_res = arb(req, opr[9:8], rr_last);

  // ==========================================================
  // request qualification
  always @* begin
    for (k = 0; k < 2; k = k + 1) begin
      case (ctl[k][8:7])
        `FCDMA_DET_LOW: extq[k] = ~external_request_in[k];
        `FCDMA_DET_HIGH: extq[k] = external_request_in[k];
        default: extq[k] = pend[k];
      endcase
    end
    for (k = 0; k < 4; k = k + 1) begin
      ready[k] = ctl[k][`FCDMA_CC_EN] & opr[`FCDMA_OP_MASTER_EN] &
                 ~ctl[k][`FCDMA_CC_END_FLAG] & ~opr[`FCDMA_OP_ADDR_ERR] &
                 ~opr[`FCDMA_OP_NMI_FLAG];
      case (ctl[k][19:16])
        `FCDMA_RS_AUTO: req[k] = ready[k];
        `FCDMA_RS_EXT: req[k] = ready[k] & (k < 2) & extq[k[0]];
        `FCDMA_RS_PERI: req[k] = ready[k] & psel(k[1] ? (k[0] ? sel23[15:8] :
                                 sel23[7:0]) : (k[0] ? sel01[15:8] :
                                 sel01[7:0]), periph_req);
        default: req[k] = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // register read mux
  always @* begin
    rd_val = 32'h00000000;
    if (is_ch) begin
      case (aix)
        `FCDMA_IDX_SRC: rd_val = src_addr[ach];
        `FCDMA_IDX_DST: rd_val = dst_addr[ach];
        `FCDMA_IDX_CNT: rd_val = {8'h00, cnt[ach]};
        default: rd_val = {12'h000, ctl[ach]};
      endcase
    end else begin
      case (avs_address)
        `FCDMA_ADDR_OPR: rd_val = {16'h0000, opr};
        `FCDMA_ADDR_SEL01: rd_val = {16'h0000, sel01};
        `FCDMA_ADDR_SEL23: rd_val = {16'h0000, sel23};
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // bus slave: one wait cycle, then the answer
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      // flag read in its set cycle sees the old zero
      if (avs_read) avs_readdata <= rd_val;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ==========================================================
  // registers and transfer engine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (c = 0; c < 4; c = c + 1) begin
        src_addr[c] <= 32'h00000000;
        dst_addr[c] <= 32'h00000000;
        cnt[c] <= 24'h000000;
        ctl[c] <= 20'h00000;
      end
      opr <= 16'h0000;
      sel01 <= 16'h0000;
      sel23 <= 16'h0000;
      st <= S_IDLE;
      cur <= 2'h0;
      beat <= 2'h0;
      rr_last <= 2'h3;
      gap <= 8'h00;
      pend <= 2'h0;
      prev_req <= 2'h0;
      mem_address <= 32'h00000000;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_writedata <= 32'h00000000;
      mem_byteenable <= 4'h0;
      request_acknowledge_out <= 2'h0;
      transfer_end_out <= 2'h0;
      channel_end_interrupt <= 4'h0;
    end else begin
      prev_req <= external_request_in;
      for (c = 0; c < 4; c = c + 1) begin
        channel_end_interrupt[c] <= ctl[c][`FCDMA_CC_END_FLAG] &
                                    ctl[c][`FCDMA_CC_INT_EN];
      end
      if (st == S_IDLE || st == S_GAP) begin
        for (c = 0; c < 2; c = c + 1) begin
          request_acknowledge_out[c] <= ~ctl[c][`FCDMA_CC_ACK_POL];
          transfer_end_out[c] <= ~ctl[c][`FCDMA_CC_END_POL];
        end
      end
      // software writes
      if (wr_go && is_ch) begin
        case (aix)
          `FCDMA_IDX_SRC: src_addr[ach] <= wr_val;
          `FCDMA_IDX_DST: dst_addr[ach] <= wr_val;
          `FCDMA_IDX_CNT: cnt[ach] <= wr_val[23:0];
          default: begin
            ctl[ach] <= (wr_val[19:0] & `FCDMA_CC_MASK) |
                        {18'h0, ctl[ach][`FCDMA_CC_END_FLAG] &
                         (wv[1] | ~avs_byteenable[0]), 1'b0};
          end
        endcase
      end else if (wr_go) begin
        case (avs_address)
          `FCDMA_ADDR_OPR: begin
            opr <= (wr_val[15:0] & `FCDMA_OP_WMASK) |
                   {13'h0, opr[2:1] & (wv[2:1] | {2{~avs_byteenable[0]}}),
                    1'b0};
          end
          `FCDMA_ADDR_SEL01: sel01 <= wr_val[15:0];
          `FCDMA_ADDR_SEL23: sel23 <= wr_val[15:0];
          default: ;
        endcase
      end
      // engine
      case (st)
        S_IDLE: begin
          if (g_res[2]) begin
            cur <= g_res[1:0];
            beat <= 2'h0;
            st <= S_CHK;
          end
        end
        S_CHK: begin
          if (!ready[cur]) begin
            st <= S_IDLE;
          end else if (beat == 2'h0 && (bad_src || bad_dst)) begin
            opr[`FCDMA_OP_ADDR_ERR] <= 1'b1;
            st <= S_IDLE;
          end else begin
            if (sgl && !sdir) begin
              // device is source: only the destination side is used
              mem_write <= 1'b1;
              mem_address <= dst_addr[cur];
              mem_byteenable <= bef(ts, dst_addr[cur][1:0]);
              mem_writedata <= 32'h00000000;
              st <= S_WR;
            end else begin
              mem_read <= 1'b1;
              mem_address <= src_addr[cur];
              mem_byteenable <= bef(ts, src_addr[cur][1:0]);
              st <= S_RD;
            end
            if (ext_mode) begin
              request_acknowledge_out[cur[0]] <= cctl[`FCDMA_CC_ACK_POL];
              if (last_unit && unit_last)
                transfer_end_out[cur[0]] <= cctl[`FCDMA_CC_END_POL];
            end
          end
        end
        S_RD: begin
          if (!mem_waitrequest) begin
            mem_read <= 1'b0;
            src_addr[cur] <= src_addr[cur] + stp;
            if (!sgl) begin
              mem_write <= 1'b1;
              mem_address <= dst_addr[cur];
              mem_byteenable <= bef(ts, dst_addr[cur][1:0]);
              mem_writedata <= repl(ts, mem_readdata, src_addr[cur][1:0]);
              st <= S_WR;
            end
          end
        end
        S_WR: begin
          if (!mem_waitrequest) begin
            mem_write <= 1'b0;
            dst_addr[cur] <= dst_addr[cur] + stp;
          end
        end
        S_GAP: begin
          if (gap == 8'h00) st <= S_IDLE;
          else gap <= gap - 8'h01;
        end
        default: st <= S_IDLE;
      endcase
      if (beat_done) begin
        request_acknowledge_out[cur[0]] <= ~cctl[`FCDMA_CC_ACK_POL];
        transfer_end_out[cur[0]] <= ~cctl[`FCDMA_CC_END_POL];
        if (!unit_last) begin
          beat <= beat + 2'h1;
          st <= S_CHK;
        end else begin
          cnt[cur] <= cnt[cur] - 24'h000001;
          rr_last <= cur;
          beat <= 2'h0;
          if (last_unit) begin
            ctl[cur][`FCDMA_CC_END_FLAG] <= 1'b1;
            st <= S_IDLE;
          end else if (cctl[`FCDMA_CC_BURST] && req[cur]) begin
            st <= S_CHK;
          end else if (cctl[`FCDMA_CC_INTM]) begin
            gap <= INTM_GAP;
            st <= S_GAP;
          end else begin
            st <= S_IDLE;
          end
        end
      end
      // edge requests latch until granted; a new edge wins
      for (c = 0; c < 2; c = c + 1) begin
        if (st == S_IDLE && g_res[2] && g_res[1:0] == c) pend[c] <= 1'b0;
        if ((ctl[c][8:7] == `FCDMA_DET_RISE && external_request_in[c] &&
             !prev_req[c]) ||
            (ctl[c][8:7] == `FCDMA_DET_FALL && !external_request_in[c] &&
             prev_req[c]))
          pend[c] <= 1'b1;
      end
      if (nmi_in) opr[`FCDMA_OP_NMI_FLAG] <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== test/fcdma_top_chk.sv
// Purpose: port assertions for the four channel transfer controller
// Assumes: bound to fcdma_top, one clock domain
// Notes: watches the register slave and the memory master handshakes
`timescale 1ns/100ps
`default_nettype none
module fcdma_top_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] mem_address,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [31:0] mem_writedata,
  input wire logic [3:0] mem_byteenable,
  input wire logic mem_waitrequest,
  input wire logic nmi_in
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ====================
  // sequences
  sequence s_idle;
    !mem_read && !mem_write;
  endsequence
  sequence s_nmi_quiet;
    nmi_in ##1 s_idle;
  endsequence
  // ====================
  // register slave
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register answer not one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("register answer longer than one cycle");
  a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved outside an answer");
  a_count_top: assert property (avs_read && avs_waitrequest && avs_address[3:2] == 2'h2
    && avs_address < 8'h40 |=> avs_readdata[31:24] == 8'h00)
    else $error("count top byte not zero");
  // ====================
  // memory master
  a_read_hold: assert property (mem_read && mem_waitrequest
    |=> mem_read && $stable(mem_address))
    else $error("memory read dropped before answer");
  a_write_hold: assert property (mem_write && mem_waitrequest
    |=> mem_write && $stable(mem_address) && $stable(mem_writedata))
    else $error("memory write changed before answer");
  a_rw_excl: assert property (!(mem_read && mem_write))
    else $error("memory read and write together");
  a_long_align: assert property ((mem_read || mem_write) && mem_byteenable == 4'hF
    |-> mem_address[1:0] == 2'h0)
    else $error("full lane access not aligned");
  a_nmi_stop: assert property (s_nmi_quiet |=> s_idle [*4])
    else $error("memory access after abort");
endmodule
bind fcdma_top fcdma_top_chk u_fcdma_top_chk (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mem_address(mem_address), .mem_read(mem_read), .mem_write(mem_write),
  .mem_writedata(mem_writedata), .mem_byteenable(mem_byteenable),
  .mem_waitrequest(mem_waitrequest), .nmi_in(nmi_in));
`default_nettype wire

// ===== test/fcdma_mem_model.sv
// Purpose: memory slave on the far side of the memory master
// Assumes: word array indexed by address bits 9:2
// Notes: answers after wait_cycles; idle read data shows inverse of last
`timescale 1ns/100ps
`default_nettype none
module fcdma_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] mem_address,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [31:0] mem_writedata,
  input wire logic [3:0] mem_byteenable,
  input wire logic [1:0] wait_cycles,
  output logic [31:0] mem_readdata,
  output logic mem_waitrequest
);
  logic [31:0] ram [0:255];
  logic [1:0] cnt;
  logic [31:0] last;
  wire req = mem_read || mem_write;
  wire [7:0] idx = mem_address[9:2];
  assign mem_waitrequest = !(req && cnt == wait_cycles);
  assign mem_readdata = mem_read ? ram[idx] : ~last;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
      last <= 32'h0;
    end else if (req && !mem_waitrequest) begin
      cnt <= 2'h0;
      if (mem_read) begin
        last <= ram[idx];
      end
      for (int i = 0; i < 4; i++) begin
        if (mem_write && mem_byteenable[i]) begin
          ram[idx][8*i +: 8] <= mem_writedata[8*i +: 8];
        end
      end
    end else if (req) begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== test/fcdma_top_bench.sv
// Purpose: self-checking bench for the four channel transfer controller
// Assumes: register bus driven as an Avalon-MM master
// Notes: one scenario per task; memory answers with set wait cycles
`timescale 1ns/100ps
`default_nettype none
`include "fcdma_defs.vh"
module fcdma_top_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [1:0] external_request_in = 2'h0;
  logic [7:0] periph_req = 8'h00;
  logic nmi_in = 1'b0;
  logic [1:0] wait_cycles = 2'h0;
  wire [31:0] avs_readdata, mem_address, mem_writedata, mem_readdata;
  wire avs_waitrequest, mem_read, mem_write, mem_waitrequest;
  wire [3:0] mem_byteenable, channel_end_interrupt;
  wire [1:0] request_acknowledge_out, transfer_end_out;
  int errors = 0;
  int checked = 0;
  int acks = 0;
  int ends = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (request_acknowledge_out[0] === 1'b1) acks++;
    if (transfer_end_out[0] === 1'b1) ends++;
  end
  fcdma_top #(.INTM_GAP(8'h02)) u_fcdma_top (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_address(mem_address), .mem_read(mem_read),
    .mem_write(mem_write), .mem_writedata(mem_writedata), .mem_byteenable(mem_byteenable),
    .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest),
    .external_request_in(external_request_in), .periph_req(periph_req), .nmi_in(nmi_in),
    .request_acknowledge_out(request_acknowledge_out), .transfer_end_out(transfer_end_out),
    .channel_end_interrupt(channel_end_interrupt));
  fcdma_mem_model u_fcdma_mem_model (.ref_clk(ref_clk), .rst(rst),
    .mem_address(mem_address), .mem_read(mem_read), .mem_write(mem_write),
    .mem_writedata(mem_writedata), .mem_byteenable(mem_byteenable),
    .wait_cycles(wait_cycles), .mem_readdata(mem_readdata),
    .mem_waitrequest(mem_waitrequest));
  // ====================
  // shared tasks
  task automatic test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) errors++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic cfg(input int ch, input logic [31:0] s, d, c, ctl);
    wr(8'(ch*16), s);
    wr(8'(ch*16+4), d);
    wr(8'(ch*16+8), c);
    wr(8'(ch*16+12), ctl);
  endtask
  task automatic wait_end(input int ch);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h0;
    while (q[1] !== 1'b1 && n < 300) begin
      rd(8'(ch*16+12), q);
      n++;
    end
    chk("end flag", 32'h1, {31'h0, q[1]});
  endtask
  function automatic logic [31:0] mb(input logic [31:0] a);
    return {24'h0, u_fcdma_mem_model.ram[a[9:2]][8*a[1:0] +: 8]};
  endfunction
  // ====================
  // scenarios
  task automatic t_regs;
    logic [31:0] q;
    for (int a = 0; a < 8'h50; a += 4) begin
      rd(8'(a), q);
      chk("reset value", 32'h0, q);
    end
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, q);
    chk("source ch1", 32'hFFFFFFFF, q);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, q);
    chk("count ch1", 32'h00FFFFFF, q);
    wr(8'h4C, 32'h12345678);
    rd(8'h4C, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_sizes;
    logic [31:0] q, s, d;
    int u;
    wr(`FCDMA_ADDR_OPR, 32'h7);
    for (int t = 0; t < 4; t++) begin
      u = (t == 3) ? 16 : (1 << t);
      s = 32'h100 + 32'(t) * 32'h40;
      d = s + 32'h100;
      wait_cycles <= 2'(t);
      cfg(t, s, d, 32'h2, 32'h7 | 32'(t << 3) | 32'(t << 11));
      wait_end(t);
      rd(8'(t*16), q);
      chk("source next", s + 32'(2*u), q);
      rd(8'(t*16+4), q);
      chk("dest next", d + 32'(2*u), q);
      rd(8'(t*16+8), q);
      chk("count left", 32'h0, q);
      chk("interrupt", 32'h1, {31'h0, channel_end_interrupt[t]});
      for (int k = 0; k < 2*u; k++) chk("moved byte", mb(s + 32'(k)), mb(d + 32'(k)));
      wr(8'(t*16+12), 32'h2);
      rd(8'(t*16+12), q);
      chk("flag kept", 32'h1, {31'h0, q[1]});
      wr(8'(t*16+12), 32'h0);
      rd(8'(t*16+12), q);
      chk("flag cleared", 32'h0, {31'h0, q[1]});
    end
    wait_cycles <= 2'h0;
  endtask
  task automatic t_nmi;
    logic [31:0] q, s;
    cfg(0, 32'h0, 32'h80, 32'h0, 32'h13);
    cyc(20);
    nmi_in <= 1'b1;
    cyc(1);
    nmi_in <= 1'b0;
    cyc(10);
    rd(`FCDMA_ADDR_OPR, q);
    chk("abort flag", 32'h1, {31'h0, q[1]});
    rd(8'h0C, q);
    chk("no early end", 32'h0, {31'h0, q[1]});
    rd(8'h08, q);
    chk("count high", 32'h00FF, {16'h0, q[31:16]});
    rd(8'h00, s);
    cyc(20);
    rd(8'h00, q);
    chk("held source", s, q);
    wr(8'h0C, 32'h2);
    wr(`FCDMA_ADDR_OPR, 32'h5);
    rd(`FCDMA_ADDR_OPR, q);
    chk("abort cleared", 32'h0, {31'h0, q[1]});
  endtask
  task automatic t_periph;
    logic [31:0] q;
    wr(`FCDMA_ADDR_SEL01, {16'h0, `FCDMA_MOD_SER1, `FCDMA_KIND_RX, 8'h00});
    cfg(1, 32'h100, 32'h300, 32'h1, 32'h00080013);
    cyc(30);
    rd(8'h18, q);
    chk("no request", 32'h1, q);
    periph_req <= 8'h04;
    cyc(30);
    rd(8'h18, q);
    chk("other request", 32'h1, q);
    periph_req <= 8'h08;
    wait_end(1);
    periph_req <= 8'h00;
    rd(8'h18, q);
    chk("periph count", 32'h0, q);
    wr(8'h1C, 32'h0);
  endtask
  task automatic t_ext;
    logic [31:0] q;
    cfg(0, 32'h100, 32'h380, 32'h2, 32'h00020693);
    cyc(30);
    rd(8'h08, q);
    chk("no ext request", 32'h2, q);
    chk("ack idle", 32'h0, {31'h0, request_acknowledge_out[0]});
    chk("ch1 ack idle", 32'h1, {31'h0, request_acknowledge_out[1]});
    acks = 0;
    ends = 0;
    external_request_in <= 2'h1;
    wait_end(0);
    external_request_in <= 2'h0;
    chk("ack seen", 32'h1, 32'(acks > 0));
    chk("end seen", 32'h1, 32'(ends > 0));
    wr(8'h0C, 32'h0);
    cfg(0, 32'h100, 32'h380, 32'h2, 32'h00020713);
    external_request_in <= 2'h1;
    cyc(1);
    external_request_in <= 2'h0;
    cyc(40);
    rd(8'h08, q);
    chk("edge count", 32'h1, q);
  endtask
  // ====================
  // main sequence and watchdog
  initial begin
    for (int i = 0; i < 256; i++) u_fcdma_mem_model.ram[i] = 32'(i) * 32'h01030507;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_sizes;
    t_nmi;
    t_periph;
    t_ext;
    test_done;
  end
  initial begin
    #1600000;
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
